// ===== hdl/evp_pkg.sv
// Constants, types and helpers shared by the exception vector and priority block.
// Assumes one 20 MHz clock domain and an active-low asynchronous reset.
package evp_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int VEC_W   = 5;
	localparam int VADDR_W = 16;
	localparam int NUM_VEC = 26;
	localparam int NUM_EXT = 4;
	localparam int NUM_PIN = NUM_EXT + 1;
	localparam int CH_NMI  = NUM_EXT;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_EDGE   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_PEND   = 4'h3;

	// ----------------------------------------------------------------
	// Edge select layout and reset values
	// ----------------------------------------------------------------
	localparam int                EDGE_NMI_BIT = 7;
	localparam logic [2:0]        EDGE_RSV_VAL = 3'h7;
	localparam logic [NUM_EXT-1:0] EDGE_EXT_RST = 4'h0;
	localparam logic              EDGE_NMI_RST = 1'b0;
	localparam logic [DATA_W-1:0] REG_RST      = 8'h00;

	// ----------------------------------------------------------------
	// Status bits
	// ----------------------------------------------------------------
	localparam int ST_WDT   = 0;
	localparam int ST_NMI   = 1;
	localparam int ST_EXT   = 2;
	localparam int ST_DISP  = 3;
	localparam int ST_TRAP  = 4;
	localparam int ST_HELD  = 5;

	// ----------------------------------------------------------------
	// Vector numbers
	// ----------------------------------------------------------------
	localparam logic [VEC_W-1:0] VEC_RESET  = 5'h00;
	localparam logic [VEC_W-1:0] VEC_NMI    = 5'h07;
	localparam logic [VEC_W-1:0] VEC_TRAP0  = 5'h08;
	localparam logic [VEC_W-1:0] VEC_BRK    = 5'h0C;
	localparam logic [VEC_W-1:0] VEC_SLEEP  = 5'h0D;
	localparam logic [VEC_W-1:0] VEC_EXT0   = 5'h0E;
	localparam logic [VEC_W-1:0] VEC_WAKE   = 5'h12;
	localparam logic [VEC_W-1:0] VEC_TMRA   = 5'h13;
	localparam logic [VEC_W-1:0] VEC_TMRW   = 5'h15;
	localparam logic [VEC_W-1:0] VEC_TMRV   = 5'h16;
	localparam logic [VEC_W-1:0] VEC_SERIAL = 5'h17;
	localparam logic [VEC_W-1:0] VEC_IIC    = 5'h18;
	localparam logic [VEC_W-1:0] VEC_ADC    = 5'h19;

	// Vectors 1..6 and 20 are never dispatched
	localparam logic [NUM_VEC-1:0] RESERVED_VECS = 26'h010007E;
	// Only these are held off by the global mask bit
	localparam logic [NUM_VEC-1:0] MASKABLE_VECS = 26'h3FFC000;

	typedef enum logic [1:0] {
		EVP_S_RST  = 2'b10,
		EVP_S_RUN  = 2'b01,
		EVP_S_DISP = 2'b11
	} evp_state_t;

	typedef struct packed {
		evp_state_t          st;
		logic [VEC_W-1:0]    vec;
		logic [VADDR_W-1:0]  vaddr;
		logic                exc_req;
		logic                chip_reset;
		logic                nmi_sel;
		logic [NUM_EXT-1:0]  ext_sel;
		logic [DATA_W-1:0]   status;
		logic [DATA_W-1:0]   mask;
		logic [DATA_W-1:0]   rdata;
		logic                int_out;
		logic                trap_pend;
		logic [1:0]          trap_code;
		logic                sleep_pend;
	} evp_top_state_t;

	typedef struct packed {
		logic                primed;
		logic [NUM_PIN-1:0]  prev;
		logic [NUM_PIN-1:0]  pend;
		logic [NUM_PIN-1:0]  hit;
	} evp_det_state_t;

	typedef struct packed {
		logic             found;
		logic [VEC_W-1:0] vec;
	} evp_win_t;

	// Each entry is one two-byte word
	function automatic logic [VADDR_W-1:0] evp_vec_addr(input logic [VEC_W-1:0] v);
		evp_vec_addr = {10'h000, v, 1'b0};
	endfunction

	// Lowest vector number wins
	function automatic evp_win_t evp_pick(input logic [NUM_VEC-1:0] req);
		evp_win_t w;
		w = '0;
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			if (req[i]) begin
				w.found = 1'b1;
				w.vec   = VEC_W'(i);
			end
		end
		evp_pick = w;
	endfunction

endpackage

// ===== hdl/evp_pend_if.sv
// Carries pin levels, edge choices and clears to the edge detector, and pending requests back from it.
// Channels 0..3 are the external request lines, channel 4 the non-maskable pin.
`timescale 1ns/1ps
interface evp_pend_if;
	import evp_pkg::*;
	logic [NUM_PIN-1:0] pins;
	logic [NUM_PIN-1:0] edge_sel;
	logic [NUM_PIN-1:0] clr;
	logic [NUM_PIN-1:0] pend;
	logic [NUM_PIN-1:0] hit;

	modport det (input pins, input edge_sel, input clr, output pend, output hit);
	modport ctl (output pins, output edge_sel, output clr, input pend, input hit);
endinterface

// ===== hdl/evp_edge_det.sv
// Edge detector with sticky pending latches for the request pins.
// Assumes pins are already synchronous to i_clk.
`timescale 1ns/1ps
module evp_edge_det
	import evp_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Pin channel
	evp_pend_if.det   pif
);
	import evp_pkg::*;

	evp_det_state_t s_r;
	evp_det_state_t s_nxt;
	logic [NUM_PIN-1:0] rise;
	logic [NUM_PIN-1:0] fall;

	always_comb begin
		s_nxt        = s_r;
		rise         = pif.pins & ~s_r.prev;
		fall         = ~pif.pins & s_r.prev;
		s_nxt.primed = 1'b1;
		s_nxt.prev   = pif.pins;
		// No detection before the first sample is held
		s_nxt.hit    = s_r.primed ? ((pif.edge_sel & rise) | (~pif.edge_sel & fall)) : '0;
		// A new edge wins over a clear in the same cycle
		s_nxt.pend   = (s_r.pend & ~pif.clr) | s_nxt.hit;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pif.pend = s_r.pend;
	assign pif.hit  = s_r.hit;

endmodule

// ===== hdl/evp_top.sv
// Exception vector and priority front end for a small processor core.
// Assumes all inputs are synchronous to i_clk; peripheral requests are levels held by
// their sources until serviced; the core pulses i_exc_done when an exception sequence ends.
//
// Overview of operation
// - Reset has top priority; after pin release dispatch vector 0 at 0x0000.
// - Watchdog overflow resets the chip and dispatches vector 0 like the pin.
// - Trap with 2-bit code dispatches vectors 8 to 11 from 0x0010.
// - Traps are taken in program execution regardless of the mask bit.
// - Mask bit 1 holds off interrupts except non-maskable pin and address break.
// - Interrupts start only after current instruction or exception sequence ends.
// - Highest fixed priority first; priority falls as vector number rises.
// - Vectors 1 to 6 and 20 are never dispatched.
// - Direct transition by sleep instruction raises vector 13 at 0x001A.
// - Four capture/compare events and second timer overflow share vector 21.
// - Third timer compare matches and overflow share vector 22.
// - Serial port receive, transmit and error events share vector 23.
// - Edge select bit 7 picks non-maskable pin edge, 0 falling, reset 0.
// - Edge select bits 3..0 pick request pin edges, 0 falling, reset 0.
// - Edge select bits 6..4 read as 1 and ignore writes.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module evp_top
	import evp_pkg::*;
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_b,
	// Register port
	input  wire logic [evp_pkg::ADDR_W-1:0] i_reg_addr,
	input  wire logic [evp_pkg::DATA_W-1:0] i_reg_wdata,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	output logic [evp_pkg::DATA_W-1:0]      o_reg_rdata,
	// Reset sources
	input  wire logic                       i_wdt_overflow,
	// Core side
	input  wire logic                       i_cond_code_imask,
	input  wire logic                       i_insn_end,
	input  wire logic                       i_exc_done,
	input  wire logic                       i_software_trap_op,
	input  wire logic [1:0]                 i_trap_code,
	input  wire logic                       i_sleep_direct,
	output logic                            o_exc_req,
	output logic [evp_pkg::VEC_W-1:0]       o_vec_num,
	output logic [evp_pkg::VADDR_W-1:0]     o_vec_addr,
	output logic                            o_chip_reset,
	// Pins
	input  wire logic                       i_nonmaskable_pin,
	input  wire logic [evp_pkg::NUM_EXT-1:0] i_ext_request_line,
	// Internal requests
	input  wire logic                       i_addr_break,
	input  wire logic                       i_wakeup_pin_group,
	input  wire logic                       i_timer_a_ovf,
	input  wire logic [4:0]                 i_timer_w_req,
	input  wire logic [2:0]                 i_timer_v_req,
	input  wire logic [3:0]                 i_serial_req,
	input  wire logic [2:0]                 i_iic_req,
	input  wire logic                       i_adc_end,
	// Status interrupt
	output logic                            o_int
);
	import evp_pkg::*;

	// ----------------------------------------------------------------
	// State and pin channel
	// ----------------------------------------------------------------
	evp_top_state_t     s_r;
	evp_top_state_t     s_nxt;
	evp_pend_if         pif ();
	logic [NUM_PIN-1:0] clr_nxt;
	logic [NUM_VEC-1:0] req;
	evp_win_t           win;
	logic [DATA_W-1:0]  status_set;
	logic               rd_status;

	evp_edge_det u_det (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.pif     (pif)
	);

	assign pif.pins     = {i_nonmaskable_pin, i_ext_request_line};
	assign pif.edge_sel = {s_r.nmi_sel, s_r.ext_sel};
	assign pif.clr      = clr_nxt;

	// ----------------------------------------------------------------
	// Request gathering
	// ----------------------------------------------------------------
	always_comb begin
		req = '0;
		req[VEC_NMI]                 = pif.pend[CH_NMI];
		req[VEC_TRAP0 + s_r.trap_code] = s_r.trap_pend;
		req[VEC_BRK]                 = i_addr_break;
		req[VEC_SLEEP]               = s_r.sleep_pend;
		req[VEC_EXT0 +: NUM_EXT]     = pif.pend[NUM_EXT-1:0];
		req[VEC_WAKE]                = i_wakeup_pin_group;
		req[VEC_TMRA]                = i_timer_a_ovf;
		req[VEC_TMRW]                = |i_timer_w_req;
		req[VEC_TMRV]                = |i_timer_v_req;
		req[VEC_SERIAL]              = |i_serial_req;
		req[VEC_IIC]                 = |i_iic_req;
		req[VEC_ADC]                 = i_adc_end;
		// Mask bit leaves non-maskable pin, traps, break and sleep untouched
		if (i_cond_code_imask) begin
			req = req & ~MASKABLE_VECS;
		end
		req = req & ~RESERVED_VECS;
		win = evp_pick(req);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt      = s_r;
		clr_nxt    = '0;
		status_set = '0;
		rd_status  = i_reg_rd && (i_reg_addr == OFS_STATUS);

		s_nxt.chip_reset = 1'b0;

		// Traps and sleep transitions are remembered until taken
		if (i_software_trap_op) begin
			s_nxt.trap_pend = 1'b1;
			s_nxt.trap_code = i_trap_code;
		end
		if (i_sleep_direct) begin
			s_nxt.sleep_pend = 1'b1;
		end

		unique case (s_r.st)
			EVP_S_RST: begin
				// First cycle after release goes straight to vector 0
				s_nxt.st      = EVP_S_DISP;
				s_nxt.vec     = VEC_RESET;
				s_nxt.vaddr   = evp_vec_addr(VEC_RESET);
				s_nxt.exc_req = 1'b1;
			end
			EVP_S_RUN: begin
				if (i_insn_end && win.found) begin
					s_nxt.st      = EVP_S_DISP;
					s_nxt.vec     = win.vec;
					s_nxt.vaddr   = evp_vec_addr(win.vec);
					s_nxt.exc_req = 1'b1;
					status_set[ST_DISP] = 1'b1;
					if (win.vec == VEC_NMI) begin
						clr_nxt[CH_NMI] = 1'b1;
					end
					if (win.vec >= VEC_EXT0 && win.vec < VEC_WAKE) begin
						clr_nxt[2'(win.vec - VEC_EXT0)] = 1'b1;
					end
					if (win.vec >= VEC_TRAP0 && win.vec < VEC_BRK) begin
						s_nxt.trap_pend = i_software_trap_op;
						status_set[ST_TRAP] = 1'b1;
					end
					if (win.vec == VEC_SLEEP) begin
						s_nxt.sleep_pend = i_sleep_direct;
					end
				end
			end
			EVP_S_DISP: begin
				// Nothing new starts until the core ends this sequence
				if (i_exc_done) begin
					s_nxt.st      = EVP_S_RUN;
					s_nxt.exc_req = 1'b0;
				end
			end
			// Unused code: recover through the reset dispatch
			default: begin
				s_nxt.st = EVP_S_RST;
			end
		endcase

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				OFS_EDGE: begin
					s_nxt.nmi_sel = i_reg_wdata[EDGE_NMI_BIT];
					s_nxt.ext_sel = i_reg_wdata[NUM_EXT-1:0];
				end
				OFS_MASK: begin
					s_nxt.mask = i_reg_wdata;
				end
				OFS_PEND: begin
					// Write one to drop a latched pin edge
					clr_nxt = clr_nxt | {i_reg_wdata[EDGE_NMI_BIT],
						i_reg_wdata[NUM_EXT-1:0]};
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// Register reads, data one cycle later
		// ------------------------------------------------------------
		s_nxt.rdata = REG_RST;
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				OFS_EDGE:   s_nxt.rdata = {s_r.nmi_sel, EDGE_RSV_VAL, s_r.ext_sel};
				OFS_STATUS: s_nxt.rdata = s_r.status;
				OFS_MASK:   s_nxt.rdata = s_r.mask;
				OFS_PEND:   s_nxt.rdata = {pif.pend[CH_NMI], 3'h0, pif.pend[NUM_EXT-1:0]};
				default:    s_nxt.rdata = REG_RST;
			endcase
		end

		// ------------------------------------------------------------
		// Status events
		// ------------------------------------------------------------
		status_set[ST_NMI] = pif.hit[CH_NMI];
		status_set[ST_EXT] = |pif.hit[NUM_EXT-1:0];
		status_set[ST_HELD] = i_cond_code_imask && i_insn_end && s_r.st == EVP_S_RUN
			&& |(pif.pend[NUM_EXT-1:0]);

		// ------------------------------------------------------------
		// Watchdog overflow acts as a chip reset
		// ------------------------------------------------------------
		if (i_wdt_overflow) begin
			s_nxt.st         = EVP_S_RST;
			s_nxt.exc_req    = 1'b0;
			s_nxt.chip_reset = 1'b1;
			s_nxt.nmi_sel    = EDGE_NMI_RST;
			s_nxt.ext_sel    = EDGE_EXT_RST;
			s_nxt.trap_pend  = 1'b0;
			s_nxt.sleep_pend = 1'b0;
			clr_nxt          = '1;
			status_set[ST_WDT] = 1'b1;
		end

		// Reading clears the sticky bits, but a new event in that cycle stays
		s_nxt.status  = (rd_status ? REG_RST : s_r.status) | status_set;
		s_nxt.int_out = |(s_nxt.status & s_nxt.mask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_r            <= '0;
			s_r.st         <= EVP_S_RST;
			s_r.vaddr      <= evp_vec_addr(VEC_RESET);
			s_r.nmi_sel    <= EDGE_NMI_RST;
			s_r.ext_sel    <= EDGE_EXT_RST;
			s_r.status     <= REG_RST;
			s_r.mask       <= REG_RST;
			s_r.rdata      <= REG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_reg_rdata  = s_r.rdata;
	assign o_exc_req    = s_r.exc_req;
	assign o_vec_num    = s_r.vec;
	assign o_vec_addr   = s_r.vaddr;
	assign o_chip_reset = s_r.chip_reset;
	assign o_int        = s_r.int_out;

endmodule

// ===== test/evp_props.sv
// Port-level checks for the exception vector block.
// Assumes it is bound into evp_top and shares its clock and reset.
`timescale 1ns/1ps
module evp_props
	import evp_pkg::*;
(
	input wire logic                         i_clk,
	input wire logic                         i_rst_b,
	input wire logic                         i_reg_rd,
	input wire logic [evp_pkg::DATA_W-1:0]   o_reg_rdata,
	input wire logic                         i_wdt_overflow,
	input wire logic                         i_cond_code_imask,
	input wire logic                         i_insn_end,
	input wire logic                         i_exc_done,
	input wire logic                         o_exc_req,
	input wire logic [evp_pkg::VEC_W-1:0]    o_vec_num,
	input wire logic [evp_pkg::VADDR_W-1:0]  o_vec_addr,
	input wire logic                         o_chip_reset
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	// ----------------------------------------------------------------
	// Reset and dispatch steps
	// ----------------------------------------------------------------
	sequence s_wdt_clear;
		o_chip_reset && !o_exc_req;
	endsequence
	sequence s_vec_zero;
		o_exc_req && o_vec_num == VEC_RESET && o_vec_addr == 16'h0000 && !o_chip_reset;
	endsequence

	a_reset_fetch: assert property ($rose(i_rst_b) |=> s_vec_zero)
		else $error("no vector 0 fetch after reset release");
	a_wdt_like_pin: assert property (i_wdt_overflow |=> s_wdt_clear ##1 s_vec_zero)
		else $error("watchdog reset did not follow the pin reset path");
	a_chip_reset_cause: assert property (o_chip_reset |-> $past(i_wdt_overflow))
		else $error("chip reset without watchdog overflow");
	a_vec_addr_word: assert property (o_exc_req |-> o_vec_addr == {10'h000, o_vec_num, 1'b0})
		else $error("vector address is not twice the number");
	a_no_reserved: assert property (o_exc_req |-> !(o_vec_num inside {[5'h01:5'h06], 5'h14}))
		else $error("reserved vector dispatched");
	a_masked_held: assert property ($rose(o_exc_req) && $past(i_cond_code_imask) |-> o_vec_num < 5'h0E)
		else $error("maskable vector taken while masked");
	a_take_boundary: assert property ($rose(o_exc_req) |-> $past(i_insn_end) || o_vec_num == 5'h00)
		else $error("vector taken off an instruction boundary");
	a_exc_hold: assert property (o_exc_req && !i_exc_done && !i_wdt_overflow |=> o_exc_req && $stable(o_vec_num))
		else $error("vector changed before the sequence ended");
	a_exc_release: assert property (o_exc_req && i_exc_done |=> !o_exc_req)
		else $error("request stayed after sequence end");
	a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data outside the answer cycle");
endmodule

bind evp_top evp_props evp_props_inst (.i_clk, .i_rst_b, .i_reg_rd, .o_reg_rdata,
	.i_wdt_overflow, .i_cond_code_imask, .i_insn_end, .i_exc_done, .o_exc_req,
	.o_vec_num, .o_vec_addr, .o_chip_reset);

// ===== test/evp_core_model.sv
// Behavioural processor core: marks instruction ends and ends exception sequences.
// Assumes the same clock and reset as the block; slow mode spaces boundaries out.
`timescale 1ns/1ps
module evp_core_model (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Handshake
	input  wire logic i_exc_req,
	input  wire logic i_slow,
	output logic      o_insn_end,
	output logic      o_exc_done
);
	logic [2:0] cnt_r;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 3'h0;
			o_insn_end <= 1'b0;
			o_exc_done <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			o_insn_end <= !i_slow || cnt_r[1:0] == 2'h3;
			// One pulse per sequence; the block drops the request an edge later
			o_exc_done <= i_exc_req && !o_exc_done && (i_slow ? cnt_r == 3'h7 : cnt_r[0]);
		end
	end
endmodule

// ===== test/evp_top_tb.sv
// Self-checking bench for the exception vector block.
// Assumes the core model answers the handshake; request pins idle high.
`timescale 1ns/1ps
module evp_top_tb;
	import evp_pkg::*;
	typedef struct packed {logic [3:0] src; logic [2:0] idx; logic [4:0] vec;} evp_row_t;
	logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_wdt_overflow, i_cond_code_imask, slow;
	logic i_software_trap_op, i_sleep_direct, i_nonmaskable_pin, i_addr_break, i_adc_end;
	logic i_wakeup_pin_group, i_timer_a_ovf, o_exc_req, o_chip_reset, o_int;
	logic i_insn_end, i_exc_done;
	logic [3:0] i_reg_addr, i_ext_request_line, i_serial_req;
	logic [7:0] i_reg_wdata, o_reg_rdata, rd;
	logic [1:0] i_trap_code;
	logic [4:0] o_vec_num, i_timer_w_req;
	logic [15:0] o_vec_addr;
	logic [2:0] i_timer_v_req, i_iic_req;
	int errors, n_checks;
	evp_row_t rows [27];

	evp_top evp_top_inst (.*);
	evp_core_model evp_core_model_inst (.i_clk, .i_rst_b, .i_exc_req(o_exc_req),
		.i_slow(slow), .o_insn_end(i_insn_end), .o_exc_done(i_exc_done));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_req(input logic lvl);
		int k;
		k = 0;
		@(posedge i_clk);
		#1;
		while (o_exc_req !== lvl && k < 40) begin
			@(posedge i_clk);
			#1;
			k++;
		end
		chk("request level", {15'h0000, lvl}, {15'h0000, o_exc_req});
	endtask
	task automatic chk_vec(input logic [4:0] v);
		wait_req(1'b1);
		chk("vector number", {11'h000, v}, {11'h000, o_vec_num});
		chk("vector address", {10'h000, v, 1'b0}, o_vec_addr);
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1;
		rd = o_reg_rdata;
		chk("register", {8'h00, exp}, {8'h00, rd});
	endtask
	task automatic drive(input evp_row_t r, input logic on);
		case (r.src)
			4'h0: i_nonmaskable_pin <= !on;
			4'h1: i_ext_request_line[r.idx] <= !on;
			4'h2: i_addr_break <= on;
			4'h3: i_wakeup_pin_group <= on;
			4'h4: i_timer_a_ovf <= on;
			4'h5: i_timer_w_req[r.idx] <= on;
			4'h6: i_timer_v_req[r.idx] <= on;
			4'h7: i_serial_req[r.idx] <= on;
			4'h8: i_iic_req[r.idx] <= on;
			4'h9: i_adc_end <= on;
			4'hA: begin
				i_software_trap_op <= on;
				i_trap_code <= r.idx[1:0];
			end
			default: i_sleep_direct <= on;
		endcase
	endtask

	initial begin
		#(50 * 8000);
		errors++;
		finish_test();
	end

	initial begin
		{i_reg_wr, i_reg_rd, i_wdt_overflow, i_cond_code_imask, i_software_trap_op} = '0;
		{i_sleep_direct, i_addr_break, i_wakeup_pin_group, i_timer_a_ovf, i_adc_end} = '0;
		{i_reg_addr, i_reg_wdata, i_trap_code, i_timer_w_req, i_timer_v_req} = '0;
		{i_iic_req, i_serial_req, rd, slow, errors, n_checks, i_rst_b} = '0;
		{i_nonmaskable_pin, i_ext_request_line} = 5'h1F;
		rows = '{'{4'h0, 3'h0, 5'h07}, '{4'h1, 3'h0, 5'h0E}, '{4'h1, 3'h1, 5'h0F},
			'{4'h1, 3'h2, 5'h10}, '{4'h1, 3'h3, 5'h11}, '{4'h2, 3'h0, 5'h0C},
			'{4'h3, 3'h0, 5'h12}, '{4'h4, 3'h0, 5'h13}, '{4'h5, 3'h0, 5'h15},
			'{4'h5, 3'h1, 5'h15}, '{4'h5, 3'h2, 5'h15}, '{4'h5, 3'h3, 5'h15},
			'{4'h5, 3'h4, 5'h15}, '{4'h6, 3'h0, 5'h16}, '{4'h6, 3'h1, 5'h16},
			'{4'h6, 3'h2, 5'h16}, '{4'h7, 3'h0, 5'h17}, '{4'h7, 3'h1, 5'h17},
			'{4'h7, 3'h2, 5'h17}, '{4'h7, 3'h3, 5'h17}, '{4'h8, 3'h0, 5'h18},
			'{4'h9, 3'h0, 5'h19}, '{4'hA, 3'h0, 5'h08}, '{4'hA, 3'h1, 5'h09},
			'{4'hA, 3'h2, 5'h0A}, '{4'hA, 3'h3, 5'h0B}, '{4'hB, 3'h0, 5'h0D}};
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		chk_vec(VEC_RESET);
		wait_req(1'b0);
		foreach (rows[i]) begin
			@(posedge i_clk);
			slow <= i[0];
			drive(rows[i], 1'b1);
			@(posedge i_clk);
			// Pins, traps and sleep are one-cycle pulses and must be latched
			if (rows[i].src < 4'h2 || rows[i].src > 4'h9)
				drive(rows[i], 1'b0);
			chk_vec(rows[i].vec);
			@(posedge i_clk);
			drive(rows[i], 1'b0);
			wait_req(1'b0);
		end
		@(posedge i_clk);
		{i_cond_code_imask, i_timer_a_ovf, i_adc_end, i_software_trap_op} <= 4'hF;
		i_trap_code <= 2'h3;
		@(posedge i_clk);
		i_software_trap_op <= 1'b0;
		chk_vec(5'h0B);
		wait_req(1'b0);
		repeat (6) @(posedge i_clk);
		#1;
		chk("masked idle", 16'h0000, {15'h0000, o_exc_req});
		@(posedge i_clk);
		i_addr_break <= 1'b1;
		chk_vec(VEC_BRK);
		@(posedge i_clk);
		i_addr_break <= 1'b0;
		wait_req(1'b0);
		@(posedge i_clk);
		i_cond_code_imask <= 1'b0;
		chk_vec(VEC_TMRA);
		@(posedge i_clk);
		i_timer_a_ovf <= 1'b0;
		wait_req(1'b0);
		chk_vec(VEC_ADC);
		@(posedge i_clk);
		i_adc_end <= 1'b0;
		wait_req(1'b0);
		reg_chk(OFS_EDGE, 8'h70);
		reg_wr(OFS_EDGE, 8'h0F);
		reg_chk(OFS_EDGE, 8'h7F);
		reg_wr(OFS_EDGE, 8'h81);
		reg_chk(OFS_EDGE, 8'hF1);
		@(posedge i_clk);
		{i_nonmaskable_pin, i_ext_request_line[0]} <= 2'h0;
		repeat (6) @(posedge i_clk);
		#1;
		chk("falling ignored", 16'h0000, {15'h0000, o_exc_req});
		@(posedge i_clk);
		{i_nonmaskable_pin, i_ext_request_line[0]} <= 2'h3;
		chk_vec(VEC_NMI);
		wait_req(1'b0);
		chk_vec(VEC_EXT0);
		wait_req(1'b0);
		@(posedge i_clk);
		i_wdt_overflow <= 1'b1;
		@(posedge i_clk);
		i_wdt_overflow <= 1'b0;
		#1;
		chk("chip reset", 16'h0001, {15'h0000, o_chip_reset});
		chk_vec(VEC_RESET);
		wait_req(1'b0);
		reg_chk(OFS_EDGE, 8'h70);
		chk("int masked", 16'h0000, {15'h0000, o_int});
		reg_wr(OFS_MASK, 8'h01);
		repeat (3) @(posedge i_clk);
		#1;
		chk("int raised", 16'h0001, {15'h0000, o_int});
		// Every event source used so far has left its sticky bit
		reg_chk(OFS_STATUS, 8'h1F);
		repeat (3) @(posedge i_clk);
		#1;
		chk("int cleared", 16'h0000, {15'h0000, o_int});
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		chk_vec(VEC_RESET);
		wait_req(1'b0);
		reg_chk(OFS_EDGE, 8'h70);
		reg_chk(4'hF, 8'h00);
		// A masked line edge stays pending until software drops it
		@(posedge i_clk);
		{i_cond_code_imask, i_ext_request_line[1]} <= 2'h2;
		@(posedge i_clk);
		i_ext_request_line[1] <= 1'b1;
		repeat (2) @(posedge i_clk);
		reg_chk(OFS_PEND, 8'h02);
		reg_chk(OFS_STATUS, 8'h24);
		reg_wr(OFS_PEND, 8'h02);
		reg_chk(OFS_PEND, 8'h00);
		@(posedge i_clk);
		i_cond_code_imask <= 1'b0;
		repeat (6) @(posedge i_clk);
		#1;
		chk("pending dropped", 16'h0000, {15'h0000, o_exc_req});
		finish_test();
	end
endmodule
